// ==== hdl/dpc_ctrl.v ====
`timescale 1ns/1ns
`include "dpc_defines.vh"
// Rules from the document
// RULE1: Enter power-down: CKE low with NOP
// RULE2: Keep CKE high during MRS, reads, writes
// RULE3: Device finishes ACT/PRE/REF after CKE low
// RULE4: Reset DLL after exit if unlocked entry
// RULE5: Device picks precharge or active power-down
// RULE6: Device disables receivers after tCPDED
// RULE7: Drive NOP during CKE fall and tCPDED
// RULE8: A12 and bank state pick DLL off/on
// RULE9: Slow exit: tXP commands, tXPDLL reads/ODT
// RULE10: Reset low ends power-down
// RULE11: Hold CKE low and high tCKE each
// RULE12: End power-down before nine refresh intervals
// RULE13: Exit with CKE high plus NOP, wait tXP
// RULE14: Device ignores ODT in self-refresh
// RULE15: Device termination enabled by MR bits
// RULE16: ODT pin level sets termination state
// RULE17: Synchronous ODT while DLL locked
// RULE18: DLL-off mode keeps ODT low
// RULE19: Termination follows ODT after latencies
// RULE20: Latency equals CWL plus AL minus two
// RULE21: Hold ODT for ODTH4 or ODTH8
// RULE22: ODTH4 is four, ODTH8 is six
// RULE23: ODT low before read, until postamble ends
// RULE24: Device re-enables termination after read drive
// RULE25: Device exposes termination flag per clock
module dpc_ctrl (
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire       clk_en,
   output reg        mem_ck,
   input  wire       req_valid,
   input  wire [2:0] req_cmd,
   input  wire       req_bl8,
   input  wire       req_odt,
   input  wire       pd_req,
   input  wire       dll_off,
   input  wire       slow_exit,
   input  wire       dll_locked,
   input  wire [7:0] rd_odt_gap,
   output reg        req_ready,
   output reg        pd_active,
   output reg        mem_cke,
   output reg        mem_cs_n,
   output reg        mem_ras_n,
   output reg        mem_cas_n,
   output reg        mem_we_n,
   output reg        mem_odt,
   output reg        mem_reset_n
);
   // -------------------------------------------------------------------
   // States
   // -------------------------------------------------------------------
   localparam [1:0] ST_RUN  = 2'h0;
   localparam [1:0] ST_PDE  = 2'h1;
   localparam [1:0] ST_PD   = 2'h2;
   localparam [1:0] ST_EXIT = 2'h3;

   reg  [1:0]           state_q;
   reg  [2:0]           ck_div_q;
   reg  [7:0]           busy_q;
   reg  [7:0]           dllwait_q;
   reg  [7:0]           cke_q;
   reg  [7:0]           odth_q;
   reg  [7:0]           rdgap_q;
   reg  [`DPC_PDW-1:0]  pd_cnt_q;
   reg                  need_dllrst_q;
   wire                 ck_step;
   wire                 pd_due;

   // -------------------------------------------------------------------
   // Memory clock divider
   // -------------------------------------------------------------------
   // CK is made here; pins move with its falling edge, so the device's
   // rising edge finds them settled for a full half period
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ck_div_q <= 3'h0;
         mem_ck   <= 1'b0;
      end else if (clk_en) begin
         if (ck_div_q == `DPC_CK_HALF) begin
            ck_div_q <= 3'h0;
            mem_ck   <= ~mem_ck;
         end else begin
            ck_div_q <= ck_div_q + 3'h1;
         end
      end
   end
   // One sequencer step per CK period, at the edge that lowers CK
   assign ck_step = (ck_div_q == `DPC_CK_HALF) & mem_ck;

   // Forced exit ahead of the refresh-interval ceiling
   assign pd_due  = (pd_cnt_q >= `DPC_PD_LIMIT - {{(`DPC_PDW-16){1'b0}}, `DPC_TREFI_CK}); // see RULE12

   // Decide whether a command needs the DLL
   function needs_dll;
      input [2:0] c;
      begin
         needs_dll = (c == `DPC_UC_RD) || (c == `DPC_UC_WR);
      end
   endfunction

   function [3:0] map_cmd;
      input [2:0] c;
      begin
         case (c)
            `DPC_UC_ACT:    map_cmd = `DPC_CMD_ACT;
            `DPC_UC_RD:     map_cmd = `DPC_CMD_RD;
            `DPC_UC_WR:     map_cmd = `DPC_CMD_WR;
            `DPC_UC_PRE:    map_cmd = `DPC_CMD_PRE;
            `DPC_UC_REF:    map_cmd = `DPC_CMD_REF;
            `DPC_UC_MRS:    map_cmd = `DPC_CMD_MRS;
            `DPC_UC_DLLRST: map_cmd = `DPC_CMD_MRS;
            default:        map_cmd = `DPC_CMD_NOP;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Main sequencer, one step per memory clock period
   // -------------------------------------------------------------------
   // Pins move once per CK period so the device samples each command once
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q       <= ST_RUN;
         busy_q        <= 8'h00;
         dllwait_q     <= 8'h00;
         cke_q         <= 8'h00;
         odth_q        <= 8'h00;
         rdgap_q       <= 8'h00;
         pd_cnt_q      <= {`DPC_PDW{1'b0}};
         need_dllrst_q <= 1'b0;
         req_ready     <= 1'b0;
         pd_active     <= 1'b0;
         mem_cke       <= 1'b0;
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DPC_CMD_DES;
         mem_odt       <= 1'b0;
         mem_reset_n   <= 1'b0;
      end else if (clk_en) begin
         req_ready   <= 1'b0;
         mem_reset_n <= 1'b1;
         if (ck_step) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DPC_CMD_NOP; // see RULE7
            if (busy_q != 8'h00)    busy_q    <= busy_q - 8'h01;
            if (dllwait_q != 8'h00) dllwait_q <= dllwait_q - 8'h01;
            if (cke_q != 8'h00)     cke_q     <= cke_q - 8'h01;
            if (odth_q != 8'h00)    odth_q    <= odth_q - 8'h01;
            if (rdgap_q != 8'h00)   rdgap_q   <= rdgap_q - 8'h01;
            case (state_q)
               ST_RUN: begin
                  mem_cke <= 1'b1;
                  // ODT low in DLL-off mode; held during read window; ODTH kept
                  if (dll_off)
                     mem_odt <= 1'b0;                            // see RULE18
                  else if (rdgap_q != 8'h00)
                     mem_odt <= 1'b0;                            // see RULE23
                  else if (req_odt && !mem_odt && dllwait_q == 8'h00) begin
                     mem_odt <= 1'b1;
                     odth_q  <= `DPC_ODTH4;                      // see RULE21
                  end else if (!req_odt && odth_q <= 8'h01 && mem_odt)
                     mem_odt <= 1'b0;                            // see RULE22
                  // Power-down only when idle and CKE has been high tCKE
                  // CKE must already stand high, so no entry straight out of reset
                  if (pd_req && mem_cke && busy_q == 8'h00 && cke_q == 8'h00 && !need_dllrst_q) begin
                     mem_cke   <= 1'b0;                          // see RULE1
                     state_q   <= ST_PDE;
                     cke_q     <= `DPC_TCKE;                     // see RULE11
                     busy_q    <= `DPC_TCPDED;                   // see RULE7
                     pd_cnt_q  <= {`DPC_PDW{1'b0}};
                     pd_active <= 1'b1;
                     need_dllrst_q <= ~dll_locked;               // see RULE4
                  end else if (req_valid && mem_cke && busy_q == 8'h00 &&
                               !(needs_dll(req_cmd) && dllwait_q != 8'h00) &&
                               !(req_cmd == `DPC_UC_RD && mem_odt && odth_q > 8'h01) && // see RULE21
                               (!need_dllrst_q || req_cmd == `DPC_UC_DLLRST)) begin // see RULE9
                     {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= map_cmd(req_cmd);
                     req_ready <= 1'b1;
                     // Long ops keep CKE high until done
                     busy_q    <= (req_cmd == `DPC_UC_MRS || req_cmd == `DPC_UC_DLLRST) ?
                                  `DPC_TMOD : 8'h01;             // see RULE2
                     if (req_cmd == `DPC_UC_DLLRST) begin
                        need_dllrst_q <= 1'b0;
                        dllwait_q     <= `DPC_TXPDLL;
                     end
                     if (req_cmd == `DPC_UC_RD) begin
                        mem_odt <= 1'b0;
                        rdgap_q <= rd_odt_gap;                   // see RULE23
                        busy_q  <= rd_odt_gap;
                     end
                     if (req_cmd == `DPC_UC_WR) begin
                        busy_q <= req_bl8 ? `DPC_ODTH8 : `DPC_ODTH4;
                        // ODT raised on this same step is registered with the write
                        if (mem_odt || (req_odt && rdgap_q == 8'h00 && !dll_off))
                           odth_q <= req_bl8 ? `DPC_ODTH8 : `DPC_ODTH4; // see RULE21
                     end
                  end
               end
               ST_PDE: begin
                  // NOP held through tCPDED before receivers shut off
                  mem_cke  <= 1'b0;
                  pd_cnt_q <= pd_cnt_q + {{(`DPC_PDW-1){1'b0}}, 1'b1};
                  if (busy_q == 8'h00)
                     state_q <= ST_PD;                           // see RULE7
               end
               ST_PD: begin
                  pd_cnt_q <= pd_cnt_q + {{(`DPC_PDW-1){1'b0}}, 1'b1};
                  if (cke_q == 8'h00 && (!pd_req || pd_due)) begin
                     mem_cke   <= 1'b1;                          // see RULE13
                     cke_q     <= `DPC_TCKE;                     // see RULE11
                     busy_q    <= `DPC_TXP;                      // see RULE13
                     dllwait_q <= slow_exit ? `DPC_TXPDLL : `DPC_TXP; // see RULE9
                     state_q   <= ST_EXIT;
                  end
               end
               ST_EXIT: begin
                  mem_cke <= 1'b1;
                  if (busy_q == 8'h00) begin
                     state_q   <= ST_RUN;
                     pd_active <= 1'b0;
                  end
               end
               default: state_q <= ST_RUN;
            endcase
            // DLL-off mode overrides every state, power-down included
            if (dll_off)
               mem_odt <= 1'b0;                                  // see RULE18
         end
      end
   end
endmodule // dpc_ctrl

// ==== hdl/dpc_defines.vh ====
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
// Command encodings on {cs_n, ras_n, cas_n, we_n}
`define DPC_CMD_NOP    4'h7
`define DPC_CMD_DES    4'hF
`define DPC_CMD_ACT    4'h3
`define DPC_CMD_RD     4'h5
`define DPC_CMD_WR     4'h4
`define DPC_CMD_PRE    4'h2
`define DPC_CMD_REF    4'h1
`define DPC_CMD_MRS    4'h0
// User command codes
`define DPC_UC_ACT     3'h0
`define DPC_UC_RD      3'h1
`define DPC_UC_WR      3'h2
`define DPC_UC_PRE     3'h3
`define DPC_UC_REF     3'h4
`define DPC_UC_MRS     3'h5
`define DPC_UC_DLLRST  3'h6
// Timing in memory clock cycles
`define DPC_TCKE       8'h03
`define DPC_TCPDED     8'h01
`define DPC_TXP        8'h03
`define DPC_TXPDLL     8'h0A
`define DPC_TMOD       8'h0C
`define DPC_ODTH4      8'h04
`define DPC_ODTH8      8'h06
`define DPC_WIDTH_T    8
// Half CK period in clk_sys cycles, minus one
`define DPC_CK_HALF    3'h7
// Power-down limit: 35036 memory clock cycles, just under nine refresh intervals
`define DPC_TREFI_CK   16'h0F3C
`define DPC_PD_LIMIT   20'h88DC
// Counter widths
`define DPC_PDW        20
`endif

// ==== testbench/dpc_ctrl_properties.sv ====
`timescale 1ns/1ns
`include "dpc_defines.vh"
// ----------------------------------------
// Pin checker
// ----------------------------------------
module dpc_ctrl_props (
   input wire clk_sys,
   input wire rstn,
   input wire dll_off,
   input wire req_ready,
   input wire pd_active,
   input wire mem_cke,
   input wire mem_cs_n,
   input wire mem_ras_n,
   input wire mem_cas_n,
   input wire mem_we_n,
   input wire mem_odt
);
   wire [3:0] cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
   wire       nop = cmd[3] | (cmd == `DPC_CMD_NOP);
   // One domain, so one clock and one reset for all
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Cycles that DLL-off mode has stood; ODT may take up to one CK period to follow
   logic [5:0] dll_off_cyc;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dll_off_cyc <= 6'h00;
      end else if (!dll_off) begin
         dll_off_cyc <= 6'h00;
      end else if (dll_off_cyc != 6'h3F) begin
         dll_off_cyc <= dll_off_cyc + 6'h01;
      end
   end
   a_cke_fall_nop: assert property ($fell(mem_cke) |-> nop && pd_active) else $error("cke fell without nop");
   a_cke_low_hold: assert property ($fell(mem_cke) |=> !mem_cke [*8]) else $error("cke low too short");
   a_cke_rise_nop: assert property ($rose(mem_cke) |-> nop [*8]) else $error("command too soon after exit");
   a_pd_cmd_quiet: assert property (pd_active |-> nop) else $error("command during power-down");
   a_cmd_cke_high: assert property (req_ready |-> mem_cke && !nop) else $error("command without cke");
   a_mrs_cke_hold: assert property (req_ready && cmd == `DPC_CMD_MRS |=> mem_cke [*8]) else $error("cke fell in mrs");
   a_dll_off_odt: assert property (dll_off_cyc > 6'h14 |-> !mem_odt) else $error("odt high in dll-off");
   a_odt_min_high: assert property ($rose(mem_odt) |=> mem_odt [*8]) else $error("odt pulse too short");
   a_rd_odt_low: assert property (req_ready && cmd == `DPC_CMD_RD |-> ##17 !mem_odt [*8]) else $error("odt high in read");
   c_pd_entry: cover property ($fell(mem_cke));
   c_odt_on: cover property ($rose(mem_odt));
   c_read: cover property (req_ready && cmd == `DPC_CMD_RD);
endmodule // dpc_ctrl_props
bind dpc_ctrl dpc_ctrl_props dpc_ctrl_props_inst (.clk_sys(clk_sys), .rstn(rstn), .dll_off(dll_off),
   .req_ready(req_ready), .pd_active(pd_active), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
   .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_odt(mem_odt));

// ==== testbench/dpc_dev_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Device model: power-down and termination
// ----------------------------------------
module dpc_dev_model #(parameter int CWL = 5, parameter int AL = 0, parameter bit RTT_EN = 1'b1) (
   input  wire  mem_ck,
   input  wire  mem_cke,
   input  wire  mem_cs_n,
   input  wire  mem_ras_n,
   input  wire  mem_cas_n,
   input  wire  mem_we_n,
   input  wire  mem_odt,
   input  wire  mem_reset_n,
   output logic in_pd,
   output logic bank_open,
   output logic term_on
);
   localparam int ODTL = CWL + AL - 2;
   logic [15:0] odt_sr;
   wire         nop = mem_cs_n | ({mem_ras_n, mem_cas_n, mem_we_n} == 3'h7);
   // Everything but reset moves on CK rises only, so the flag can be checked per cycle
   always @(posedge mem_ck or negedge mem_reset_n) begin
      if (!mem_reset_n) begin
         in_pd <= 1'b0;
         term_on <= 1'b0;
         odt_sr <= '0;
         bank_open <= 1'b0;
      end else begin
         if (!in_pd && !mem_cke && nop) in_pd <= 1'b1;
         if (in_pd && mem_cke && nop) in_pd <= 1'b0;
         if (!in_pd && mem_cke && !nop && !mem_ras_n) bank_open <= mem_cas_n & mem_we_n;
         odt_sr <= {odt_sr[14:0], mem_odt};
         term_on <= RTT_EN & odt_sr[ODTL-1];
      end
   end
endmodule // dpc_dev_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`include "dpc_defines.vh"
module testbench;
   logic       clk_sys = 0, rstn = 0, req_valid = 0, req_bl8 = 0, req_odt = 0;
   logic       pd_req = 0, dll_off = 0, slow_exit = 0, dll_locked = 1;
   logic [2:0] req_cmd = 3'h0;
   wire        req_ready, pd_active, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_odt, mem_reset_n;
   wire        dev_pd, dev_term, dev_open, mem_ck;
   int         miscompares = 0, tests_run = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   dpc_ctrl dpc_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .mem_ck(mem_ck), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bl8(req_bl8), .req_odt(req_odt), .pd_req(pd_req), .dll_off(dll_off),
      .slow_exit(slow_exit), .dll_locked(dll_locked), .rd_odt_gap(8'h08), .req_ready(req_ready),
      .pd_active(pd_active), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
      .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_odt(mem_odt), .mem_reset_n(mem_reset_n));
   dpc_dev_model dpc_dev_model_inst (.mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
      .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_odt(mem_odt), .mem_reset_n(mem_reset_n),
      .in_pd(dev_pd), .bank_open(dev_open), .term_on(dev_term));
   task automatic check(input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Request held until acknowledged or for lim clk_sys cycles; a refusal simply never answers
   task automatic issue(input logic [2:0] c, input int lim, output logic got);
      got = 0;
      @(negedge clk_sys);
      req_valid = 1;
      req_cmd = c;
      for (int n = 0; n < lim && !got; n++) begin
         @(posedge clk_sys);
         #1 got = req_ready;
      end
      @(negedge clk_sys);
      req_valid = 0;
   endtask
   task automatic wait_pd(input logic lvl);
      for (int n = 0; n < 3000 && pd_active !== lvl; n++) @(negedge clk_sys);
      check(pd_active, lvl);
      repeat (40) @(negedge clk_sys);
   endtask
   task automatic pd_cycle;
      logic g;
      issue(`DPC_UC_MRS, 600, g);
      check(g, 1'b1);
      pd_req = 1;
      wait_pd(1'b1);
      check(mem_cke, 1'b0);
      check(dev_pd, 1'b1);
      issue(`DPC_UC_PRE, 300, g);
      check(g, 1'b0);
      pd_req = 0;
      wait_pd(1'b0);
      check(mem_cke, 1'b1);
      check(dev_pd, 1'b0);
   endtask
   task automatic t_fast;
      logic g;
      issue(`DPC_UC_ACT, 600, g);
      check(g, 1'b1);
      repeat (20) @(negedge clk_sys);
      check(dev_open, 1'b1);
      pd_cycle;
      issue(`DPC_UC_RD, 600, g);
      check(g, 1'b1);
      $display("test fast_exit done");
   endtask
   task automatic t_slow;
      logic g;
      slow_exit = 1;
      dll_locked = 0;
      pd_cycle;
      issue(`DPC_UC_RD, 400, g);
      check(g, 1'b0);
      issue(`DPC_UC_DLLRST, 600, g);
      check(g, 1'b1);
      issue(`DPC_UC_RD, 600, g);
      check(g, 1'b1);
      slow_exit = 0;
      dll_locked = 1;
      $display("test slow_exit done");
   endtask
   task automatic t_odt;
      logic g;
      req_bl8 = 1;
      req_odt = 1;
      issue(`DPC_UC_WR, 600, g);
      repeat (120) @(negedge clk_sys);
      check(mem_odt, 1'b1);
      check(dev_term, 1'b1);
      issue(`DPC_UC_RD, 600, g);
      repeat (40) @(negedge clk_sys);
      check(mem_odt, 1'b0);
      req_odt = 0;
      req_bl8 = 0;
      $display("test odt done");
   endtask
   task automatic t_dll;
      dll_off = 1;
      repeat (200) @(negedge clk_sys);
      req_odt = 1;
      repeat (80) @(negedge clk_sys);
      check(mem_odt, 1'b0);
      req_odt = 0;
      dll_off = 0;
      $display("test dll_off done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard, far above the expected run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (3) @(negedge clk_sys);
      rstn = 1;
      t_fast;
      t_slow;
      t_odt;
      t_dll;
      tally_and_finish;
   end
endmodule // testbench
